/* pkg/tbm_cfg.svh */
`ifndef TBM_CFG_SVH
`define TBM_CFG_SVH
// How it works
// - bit rate is clk/2 over scale times entries
// - polarity 0 upper sideband, 1 lower sideband
// - modulator runs only while enable is set
// - mode bit 1 selects ASK, 0 FSK
// - access bit gives software the transmit RAM
// - RAM data and pointer writes need access bit
// - 64-entry RAM addressed by 6-bit pointer
// - data write lands at current pointer entry
// - shift enable gates shifting the transmit byte
// - busy flag in state bit 7, wait for 0
// - 9-bit sample from quarter-wave sine table
// - phase step is four times the offset
// - FSK adds current RAM value to step for a one bit, subtracts it for zero
// - pointer counts entries per bit, scale paces

// register offsets
`define TBM_A_RAMDATA 8'hc9
`define TBM_A_PTR 8'hca
`define TBM_A_TXBUF 8'hcb
`define TBM_A_STEP 8'hd1
`define TBM_A_SCALE 8'hd2
`define TBM_A_CTRL 8'hd3
`define TBM_A_IRQST 8'he0
`define TBM_A_IRQMSK 8'he1
`define TBM_A_STATE 8'heb

// control field positions
`define TBM_B_POL 5
`define TBM_B_EN 4
`define TBM_B_ASK 3
`define TBM_B_ACC 2
`define TBM_B_SHEN 1

// state register fields
`define TBM_B_BUSY 7
`define TBM_B_RSV 6

// interrupt status bits
`define TBM_IRQ_EMPTY 0
`define TBM_IRQ_UNDER 1

// reset values
`define TBM_CTRL_RST 8'h00
`define TBM_BYTE_RST 8'h00
`define TBM_IRQ_RST 2'h0

// clocks per RAM sampling tick
`define TBM_SAMPLE_DIV 2
`endif

/* pkg/tbm_pkg.sv */
package tbm_pkg;
   // one register byte
   typedef logic [7:0] tbm_byte_t;
   // signed baseband sample for a converter
   typedef logic signed [8:0] tbm_sample_t;
   // quarter-wave sine magnitudes
   typedef tbm_byte_t tbm_lut_t [64];
   // byte shifter states
   typedef enum {st_idle, st_shift} tbm_state_t;
endpackage

/* pkg/tbm_ram_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface tbm_ram_if #(
   parameter int AW = 6,
   parameter int DW = 8
);
   logic we; // write strobe
   logic [AW-1:0] waddr; // write entry
   logic [AW-1:0] raddr; // read entry
   logic [DW-1:0] wdata; // write value
   logic [DW-1:0] rdata; // registered read value
   modport ctl(output we, waddr, raddr, wdata, input rdata);
   modport mem(input we, waddr, raddr, wdata, output rdata);
endinterface
`default_nettype wire

/* rtl/tbm_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module tbm_ram #(
   parameter int AW = 6,
   parameter int DW = 8
) (
   input wire logic clk, // sample clock
   input wire logic reset_n, // async reset, active low
   input wire logic ce, // freezes the memory while low
   tbm_ram_if.mem port // controller side
);
   import tbm_pkg::*;
   // storage carries no reset, contents are undefined at power up
   logic [DW-1:0] mem_r [2**AW];

   // write port
   always_ff @(posedge clk) begin
      if (ce && port.we) begin
         mem_r[port.waddr] <= port.wdata;
      end
   end

   // read data always leave a flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port.rdata <= '0;
      end else if (ce) begin
         port.rdata <= mem_r[port.raddr];
      end
   end
endmodule
`default_nettype wire

/* rtl/tbm_modulator.sv */
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tbm_cfg.svh"
module tbm_modulator #(
   parameter int RAM_DEPTH = 64
) (
   input wire logic clk, // baseband sample clock
   input wire logic reset_n, // async reset, active low
   input wire logic ce, // freezes all state while low
   input wire logic [7:0] addr, // register address
   input wire tbm_pkg::tbm_byte_t wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output tbm_pkg::tbm_byte_t rdata, // read data, cycle after rd
   output tbm_pkg::tbm_sample_t i_sample, // in-phase sample
   output tbm_pkg::tbm_sample_t q_sample, // quadrature sample
   output logic irq // level interrupt
);
   import tbm_pkg::*;
   localparam int AW = $clog2(RAM_DEPTH);

   // builds the sine quarter from a parabola, peak near full scale
   function automatic tbm_lut_t make_lut();
      tbm_lut_t t;
      int x;
      for (int i = 0; i < 64; i++) begin
         x = 2 * i + 1;
         t[i] = 8'((4 * x * (256 - x) * 255) / 65536);
      end
      return t;
   endfunction
   // sine half of the table, cosine is the mirrored read
   localparam tbm_lut_t QSIN = make_lut();

   // register state
   tbm_byte_t ctrl_r; // control bits
   logic [AW-1:0] ptr_r; // RAM pointer and entries per bit
   tbm_byte_t step_r; // baseband frequency step
   tbm_byte_t scale_r; // entry pacing
   tbm_byte_t txbuf_r; // transmit byte buffer
   logic busy_r; // buffer holds an unsent byte
   logic [1:0] irq_st_r; // sticky events
   logic [1:0] irq_mk_r; // event enables
   tbm_byte_t rdata_r; // register read data
   logic ram_rd_r; // last read came from the RAM

   // timing and shifting state
   logic tick_r; // sampling half-rate toggle
   tbm_byte_t sc_r; // ticks within an entry
   logic [AW-1:0] entry_r; // entry within the bit
   tbm_state_t st_r; // shifter state
   tbm_byte_t sh_r; // shift register, msb out first
   logic [2:0] bits_r; // bits left after the current one
   logic [11:0] phase_r; // phase accumulator
   logic [11:0] phase_nxt; // next phase

   // shorthands
   logic wr_go; // accepted write
   logic acc; // software owns the RAM
   logic run; // modulation active
   logic shift_go; // shifting allowed
   logic tick; // RAM sampling tick
   logic scale_end; // last tick of an entry
   logic bit_end; // last tick of a bit
   logic load; // buffer moves into the shifter
   logic ev_under; // shifter ran dry
   logic cur_bit; // data bit on air
   tbm_byte_t ram_val; // current RAM value

   tbm_ram_if #(.AW(AW), .DW(8)) ram_bus();

   assign wr_go = ce && wr;
   assign acc = ctrl_r[`TBM_B_ACC];
   // running needs enable and normal mode
   assign run = ctrl_r[`TBM_B_EN] && !acc;
   assign shift_go = run && ctrl_r[`TBM_B_SHEN];
   assign ram_val = ram_bus.rdata;
   assign cur_bit = (st_r == st_shift) && sh_r[7];

   // memory lives in its own module
   tbm_ram #(.AW(AW), .DW(8)) u_ram (
      .clk(clk),
      .reset_n(reset_n),
      .ce(ce),
      .port(ram_bus.ctl)
   );

   // software writes only reach the RAM in access mode
   assign ram_bus.we = wr_go && (addr == `TBM_A_RAMDATA) && acc;
   assign ram_bus.waddr = ptr_r;
   assign ram_bus.wdata = wdata;
   // access mode reads the pointed entry, else the walk
   assign ram_bus.raddr = acc ? ptr_r : entry_r;

   // configuration registers, write only to software except the mask, which reads back
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_r <= `TBM_CTRL_RST;
         step_r <= `TBM_BYTE_RST;
         scale_r <= `TBM_BYTE_RST;
         irq_mk_r <= `TBM_IRQ_RST;
      end else if (wr_go) begin
         if (addr == `TBM_A_CTRL) begin
            // bit 6 is unimplemented
            ctrl_r <= wdata & 8'hbf;
         end else if (addr == `TBM_A_STEP) begin
            step_r <= wdata;
         end else if (addr == `TBM_A_SCALE) begin
            scale_r <= wdata;
         end else if (addr == `TBM_A_IRQMSK) begin
            irq_mk_r <= wdata[1:0];
         end
      end
   end

   // pointer is locked outside access mode so a running walk
   // cannot have its length changed mid-bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_r <= '0;
      end else if (wr_go && addr == `TBM_A_PTR && acc) begin
         ptr_r <= wdata[AW-1:0];
      end
   end

   // transmit buffer and its busy flag
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txbuf_r <= `TBM_BYTE_RST;
         busy_r <= 1'b0;
      end else if (wr_go && addr == `TBM_A_TXBUF) begin
         // a write in the load cycle wins, the new byte waits
         txbuf_r <= wdata;
         busy_r <= 1'b1;
      end else if (load) begin
         busy_r <= 1'b0;
      end
   end

   // sticky events, write one to clear, a new event wins
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_st_r <= `TBM_IRQ_RST;
      end else if (ce) begin
         irq_st_r <= (irq_st_r &
            ~((wr && addr == `TBM_A_IRQST) ? wdata[1:0] : 2'h0)) |
            {ev_under, load};
      end
   end

   assign irq = |(irq_st_r & irq_mk_r);

   // read path; write-only registers read as zero
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= `TBM_BYTE_RST;
         ram_rd_r <= 1'b0;
      end else if (ce) begin
         ram_rd_r <= rd && (addr == `TBM_A_RAMDATA) && acc;
         if (!rd) begin
            rdata_r <= 8'h00;
         end else if (addr == `TBM_A_STATE) begin
            // reserved bit 6 reads one
            rdata_r <= {busy_r, 1'b1, 6'h00};
         end else if (addr == `TBM_A_IRQST) begin
            rdata_r <= {6'h00, irq_st_r};
         end else if (addr == `TBM_A_IRQMSK) begin
            rdata_r <= {6'h00, irq_mk_r};
         end else begin
            rdata_r <= 8'h00;
         end
      end
   end

   assign rdata = ram_rd_r ? ram_val : rdata_r;

   // sampling tick every second clock gives the one-half factor
   assign tick = run && tick_r;
   assign scale_end = tick && (sc_r == scale_r - 8'h01);
   assign bit_end = scale_end &&
      (entry_r == ptr_r - AW'(1));

   // tick toggle; a zero scale or count wraps to full range
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= run ? !tick_r : 1'b0;
      end
   end

   // scale counter and RAM walk
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sc_r <= 8'h00;
         entry_r <= '0;
      end else if (ce) begin
         if (!run) begin
            sc_r <= 8'h00;
            entry_r <= '0;
         end else if (scale_end) begin
            sc_r <= 8'h00;
            // restart at zero for the next bit
            entry_r <= bit_end ? '0 : entry_r + AW'(1);
         end else if (tick) begin
            sc_r <= sc_r + 8'h01;
         end
      end
   end

   // a byte is taken when idle or at the end of the last bit
   assign load = ce && shift_go && busy_r &&
      (st_r == st_idle || (bit_end && bits_r == 3'h0));
   assign ev_under = ce && shift_go && st_r == st_shift &&
      bit_end && bits_r == 3'h0 && !busy_r;

   // byte shifter; holds its place while shifting is off
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= st_idle;
         sh_r <= 8'h00;
         bits_r <= 3'h0;
      end else if (ce && shift_go) begin
         case (st_r)
            st_idle: begin
               if (busy_r) begin
                  sh_r <= txbuf_r;
                  bits_r <= 3'h7;
                  st_r <= st_shift;
               end
            end
            st_shift: begin
               if (bit_end) begin
                  if (bits_r != 3'h0) begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     bits_r <= bits_r - 3'h1;
                  end else if (busy_r) begin
                     sh_r <= txbuf_r;
                     bits_r <= 3'h7;
                  end else begin
                     // underrun: data stops; FSK carrier stays, ASK envelope drops to zero
                     st_r <= st_idle;
                  end
               end
            end
            default: begin
               st_r <= st_idle;
            end
         endcase
      end
   end

   // phase step: base from offset, FSK deviates by RAM value
   always_comb begin
      phase_nxt = phase_r + {2'b00, step_r, 2'b00};
      if (!ctrl_r[`TBM_B_ASK]) begin
         // one shifts up, zero shifts down by the RAM value
         if (cur_bit) begin
            phase_nxt = phase_nxt + {4'h0, ram_val};
         end else begin
            phase_nxt = phase_nxt - {4'h0, ram_val};
         end
      end
   end

   // accumulator wraps modulo 4096, parked at zero while not running
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_r <= 12'h000;
      end else if (ce) begin
         phase_r <= run ? phase_nxt : 12'h000;
      end
   end

   // sample synthesis from the quarter table
   logic [1:0] quad; // phase quadrant
   logic [5:0] idx; // position in the quarter
   tbm_byte_t cos_mag; // cosine magnitude
   tbm_byte_t sin_mag; // sine magnitude
   tbm_byte_t amp; // envelope
   logic [15:0] i_prod; // scaled cosine
   logic [15:0] q_prod; // scaled sine
   logic i_neg; // cosine sign
   logic q_neg; // sine sign after polarity

   assign quad = phase_r[11:10];
   assign idx = phase_r[9:4];
   assign cos_mag = quad[0] ? QSIN[idx] : QSIN[~idx];
   assign sin_mag = quad[0] ? QSIN[~idx] : QSIN[idx];
   assign i_neg = quad[1] ^ quad[0];
   // negative polarity flips Q, moving to the lower sideband
   assign q_neg = quad[1] ^ ctrl_r[`TBM_B_POL];
   // ASK keys the RAM envelope with the data bit
   assign amp = ctrl_r[`TBM_B_ASK] ?
      (cur_bit ? ram_val : 8'h00) : 8'hff;
   assign i_prod = cos_mag * amp;
   assign q_prod = sin_mag * amp;

   // output samples come from flops, zero when inactive
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         i_sample <= '0;
         q_sample <= '0;
      end else if (ce) begin
         if (!run) begin
            i_sample <= '0;
            q_sample <= '0;
         end else begin
            i_sample <= i_neg ? -$signed({1'b0, i_prod[15:8]}) :
               $signed({1'b0, i_prod[15:8]});
            q_sample <= q_neg ? -$signed({1'b0, q_prod[15:8]}) :
               $signed({1'b0, q_prod[15:8]});
         end
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_buf_write;
      ce && wr && addr == `TBM_A_TXBUF;
   endsequence
   sequence s_take;
      load && !(wr && addr == `TBM_A_TXBUF);
   endsequence

   a_busy_set: assert property (s_buf_write |=> busy_r)
      else $error("busy not set by buffer write");
   a_busy_clear: assert property (s_take |=> !busy_r)
      else $error("busy not cleared on load");
   a_ram_guard: assert property (ram_bus.we |-> acc)
      else $error("RAM written outside access mode");
   a_ptr_lock: assert property (
      wr && addr == `TBM_A_PTR && !acc |=> $stable(ptr_r))
      else $error("pointer changed outside access mode");
   a_mod_off: assert property (
      ce && !run |=> i_sample == 0 && q_sample == 0)
      else $error("samples while inactive");
   a_shift_hold: assert property (
      ce && !shift_go |=> $stable(sh_r) && $stable(st_r))
      else $error("shifter moved while disabled");
   a_ask_gap: assert property (ce && run && ctrl_r[`TBM_B_ASK] &&
      st_r == st_idle |=> i_sample == 0)
      else $error("ASK carrier without data");
   a_entry_pace: assert property (ce && run && !scale_end |=>
      $stable(entry_r))
      else $error("entry advanced early");
   a_fsk_step: assert property (ce && run && !ctrl_r[`TBM_B_ASK] |=>
      phase_r == $past(phase_nxt))
      else $error("phase step wrong");
endmodule
`default_nettype wire

/* tb/tbm_dac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// converter pair model: it only integrates what it is given, so a frozen
// or stuck sample stream shows up as a wrong sum or a missing crossing
module tbm_dac_model (
   input wire logic clk, // sample clock
   input wire tbm_pkg::tbm_sample_t i_in, // in-phase code
   input wire tbm_pkg::tbm_sample_t q_in, // quadrature code
   output var int sum_i, // running sum of i codes
   output var int sum_q, // running sum of q codes
   output var int n_cross // rising zero crossings of i
);
   import tbm_pkg::*;
   tbm_sample_t last_i = '0; // previous i code
   initial begin
      sum_i = 0;
      sum_q = 0;
      n_cross = 0;
   end
   // one conversion per clock on each converter
   always @(posedge clk) begin
      sum_i <= sum_i + int'(i_in);
      sum_q <= sum_q + int'(q_in);
      // negative to non-negative marks one baseband period
      if (last_i < 0 && i_in >= 0) begin
         n_cross <= n_cross + 1;
      end
      last_i <= i_in;
   end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbm_cfg.svh"
module tb_top;
   import tbm_pkg::*;
   localparam tbm_byte_t c_en = 8'(1 << `TBM_B_EN); // run bit
   localparam tbm_byte_t c_sh = 8'(1 << `TBM_B_SHEN); // shift bit
   localparam tbm_byte_t c_acc = 8'(1 << `TBM_B_ACC); // ram access bit
   localparam tbm_byte_t c_ask = 8'(1 << `TBM_B_ASK); // ask mode bit
   localparam tbm_byte_t c_pol = 8'(1 << `TBM_B_POL); // polarity bit
   logic clk = 1'b0; // sample clock
   logic reset_n = 1'b0; // async reset, active low
   logic ce = 1'b1; // clock enable, high except in the freeze test
   logic [7:0] addr = 8'h00; // register address
   tbm_byte_t wdata = 8'h00; // write data
   logic wr = 1'b0; // write strobe
   logic rd = 1'b0; // read strobe
   tbm_byte_t rdata; // read data
   tbm_sample_t i_sample; // in-phase sample
   tbm_sample_t q_sample; // quadrature sample
   logic irq; // interrupt level
   int sum_i; // model i sum
   int sum_q; // model q sum
   int n_cross; // model crossing count
   int num_errors = 0; // mismatches
   int n_tests = 0; // comparisons
   int sc[3] = '{2, 3, 1}; // scale values tried
   int pt[3] = '{4, 5, 1}; // entries per bit tried
   int ai, aq, ax, bi, bq, bx, n, e; // run results and counts
   tbm_byte_t d, p; // random ram value and entry
   // 125 MHz
   always #4 clk = ~clk;
   tbm_modulator #(.RAM_DEPTH(64)) dut (.clk(clk), .reset_n(reset_n),
      .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .i_sample(i_sample), .q_sample(q_sample), .irq(irq));
   tbm_dac_model dac (.clk(clk), .i_in(i_sample), .q_in(q_sample),
      .sum_i(sum_i), .sum_q(sum_q), .n_cross(n_cross));
   // four-state compare, so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s: got %0h exp %0h", $time, msg, got, exp);
      end
   endtask
   task automatic test_done();
      $display("errors %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one-cycle write strobe
   task automatic wreg(input logic [7:0] a, input tbm_byte_t v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe
   task automatic rcmp(input logic [7:0] a, input tbm_byte_t x,
                       input string msg);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, x, msg);
   endtask
   // load every entry with v, then leave cnt entries per bit
   task automatic fill(input tbm_byte_t v, input tbm_byte_t cnt);
      wreg(`TBM_A_CTRL, c_acc);
      for (int k = 0; k < 64; k++) begin
         wreg(`TBM_A_PTR, 8'(k));
         wreg(`TBM_A_RAMDATA, v);
      end
      wreg(`TBM_A_PTR, cnt);
      wreg(`TBM_A_CTRL, 8'h00);
   endtask
   // stopped first so every run starts from phase zero; 330 cycles is
   // not a whole number of periods, so the sums are not trivially zero
   task automatic run(input tbm_byte_t c, output int di, output int dq,
                      output int dx);
      int i0, q0, x0;
      wreg(`TBM_A_CTRL, 8'h00);
      repeat (4) @(posedge clk);
      chk({i_sample, q_sample}, 0, "stopped output");
      i0 = sum_i;
      q0 = sum_q;
      x0 = n_cross;
      wreg(`TBM_A_CTRL, c);
      repeat (330) @(posedge clk);
      di = sum_i - i0;
      dq = sum_q - q0;
      dx = n_cross - x0;
   endtask
   // watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      test_done();
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      void'($urandom(28703));
      rcmp(`TBM_A_STATE, 8'h40, "state after reset");
      // read data stand for one cycle only, then fall back to zero
      @(posedge clk);
      #1;
      chk(rdata, 8'h00, "read data one cycle");
      rcmp(8'h00, 8'h00, "unmapped read");
      // ram loading, pointer width and access gating
      for (int k = 0; k < 4; k++) begin
         d = 8'($urandom);
         p = 8'($urandom) & 8'h3f;
         wreg(`TBM_A_CTRL, c_acc);
         wreg(`TBM_A_PTR, p);
         wreg(`TBM_A_RAMDATA, d);
         rcmp(`TBM_A_RAMDATA, d, "ram entry");
         wreg(`TBM_A_PTR, p | 8'hc0);
         rcmp(`TBM_A_RAMDATA, d, "pointer width");
         wreg(`TBM_A_CTRL, 8'h00);
         wreg(`TBM_A_PTR, p ^ 8'h01);
         wreg(`TBM_A_RAMDATA, ~d);
         wreg(`TBM_A_CTRL, c_acc);
         rcmp(`TBM_A_RAMDATA, d, "gated write");
      end
      // byte time from buffer write to underrun
      for (int k = 0; k < 3; k++) begin
         wreg(`TBM_A_CTRL, c_acc);
         wreg(`TBM_A_PTR, 8'(pt[k]));
         wreg(`TBM_A_CTRL, 8'h00);
         wreg(`TBM_A_SCALE, 8'(sc[k]));
         wreg(`TBM_A_IRQST, 8'h03);
         wreg(`TBM_A_IRQMSK, 8'h02);
         wreg(`TBM_A_CTRL, c_en | c_sh);
         wreg(`TBM_A_TXBUF, 8'($urandom));
         n = 0;
         while (irq !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
         end
         // first bit may start mid-walk, so allow seven to eight bits
         e = 16 * sc[k] * pt[k];
         chk(n >= e - 2 * sc[k] * pt[k] - 2 && n <= e + 6, 1, "byte time");
      end
      // busy flag, shift gating and the empty interrupt
      wreg(`TBM_A_CTRL, c_en);
      wreg(`TBM_A_IRQST, 8'h03);
      wreg(`TBM_A_IRQMSK, 8'h01);
      wreg(`TBM_A_TXBUF, 8'ha5);
      repeat (5) @(posedge clk);
      rcmp(`TBM_A_STATE, 8'hc0, "busy while shift off");
      chk(irq, 1'b0, "no load without shift");
      wreg(`TBM_A_CTRL, c_en | c_sh);
      repeat (3) @(posedge clk);
      rcmp(`TBM_A_STATE, 8'h40, "busy cleared on load");
      chk(irq, 1'b1, "empty interrupt");
      wreg(`TBM_A_IRQMSK, 8'h00);
      #1;
      chk(irq, 1'b0, "masked interrupt");
      repeat (30) @(posedge clk);
      wreg(`TBM_A_IRQST, 8'h01);
      rcmp(`TBM_A_IRQST, 8'h02, "one bit cleared");
      // sample generation
      fill(8'h00, 8'h04);
      wreg(`TBM_A_STEP, 8'h40);
      wreg(`TBM_A_SCALE, 8'h02);
      run(c_en, ai, aq, ax);
      chk(ax >= 19 && ax <= 22, 1, "baseband period");
      chk(aq != 0, 1, "quadrature present");
      run(c_en | c_pol, bi, bq, bx);
      chk(bi, ai, "in-phase kept");
      chk(bq, -aq, "quadrature negated");
      run(c_en | c_ask, bi, bq, bx);
      chk(bi | bq, 0, "ask idle envelope");
      run(c_en | c_acc, bi, bq, bx);
      chk(bi | bq, 0, "access mode silent");
      fill(8'h40, 8'h04);
      run(c_en, ai, aq, ax);
      chk(ax >= 14 && ax <= 17, 1, "fsk deviation");
      // clock enable low must freeze the running sample stream
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      #1;
      ai = int'(i_sample);
      repeat (4) @(posedge clk);
      #1;
      chk(int'(i_sample), ai, "frozen by clock enable");
      @(posedge clk);
      ce <= 1'b1;
      // keyed carrier: all-ones byte turns the ASK envelope on
      wreg(`TBM_A_CTRL, c_en | c_ask | c_sh);
      wreg(`TBM_A_TXBUF, 8'hff);
      repeat (20) @(posedge clk);
      #1;
      chk(i_sample != 0 || q_sample != 0, 1, "ask keyed carrier");
      wreg(`TBM_A_CTRL, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
